/* File: cdor_regs.sv */
`timescale 1ns/1ps
`include "cdor_consts.svh"

// Function
// - Override bit is clear after reset; detection machine owns the enables.
// - Override clear: stored bits 6..0 never drive the detection circuits.
// - Override set: bits 6..0 drive the detection circuit enables through one flop.
// - Bit 0 enables the single-ended line receivers; resets to 0, read/write.
// - Bit 1 turns on the contact current source on the positive line.
// - Bit 2 enables the data-line voltage source for detection.
// - Bit 3 swaps the detection attachment between lines, not the signal path.
// - Bit 4 enables the data-line current sink for detection.
// - Bit 5 connects the pull-down resistor on the positive line.
// - Bit 6 connects the pull-down resistor on the negative line.
// - Status bit 0 reads 1 when the line voltage comparator tripped.
// - Status bit 1 reads 1 when the positive line is above threshold.
// - Status bit 2 reads 1 when the negative line is above threshold.
// - Status bit 3 reads 1 when a high-current shorted charger is seen.
// - Dead-battery variant: limit on by default, path waits for host traffic.
// - Writes to read-only or undefined registers change no register; they still count as host traffic.
// - Only the low four address bits select a register.
// - Main status bit 4 reads 1 once automatic detection has finished.

module cdor_regs
  import cdor_pkg::*;
#(
  parameter bit DEAD_BATTERY = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port from the serial slave engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire cdor_byte_type reg_wdata_i,
  output cdor_byte_type reg_rdata_o,
  output logic reg_rvalid_o,
  // Detection state machine
  input wire cdor_enables_type fsm_en_i,
  input wire logic det_done_i,
  input wire cdor_kind_type charger_kind_i,
  // Analog comparators and supply monitor
  input wire logic line_voltage_tripped_i,
  input wire logic pos_line_high_i,
  input wire logic neg_line_high_i,
  input wire logic high_current_charger_seen_i,
  input wire logic supply_ok_i,
  input wire logic auto_switch_ok_i,
  // Detection circuit enables
  output logic single_ended_rx_on_o,
  output logic contact_source_on_o,
  output logic line_voltage_source_on_o,
  output logic detect_line_swap_o,
  output logic line_current_sink_on_o,
  output logic pos_line_pulldown_on_o,
  output logic neg_line_pulldown_on_o,
  // Supply path controls
  output logic protection_switch_closed_o,
  output logic current_limit_on_o,
  output logic mux1_on_o,
  output logic mux2_on_o
);

  // ==========================================================
  // Declarations
  cdor_byte_type ctrl_reg, next_ctrl_reg;
  cdor_byte_type config_reg, next_config_reg;
  logic [3:0] cmps_reg, next_cmps_reg;
  logic host_seen, next_host_seen;
  cdor_byte_type rdata, next_rdata;
  logic rvalid, next_rvalid;
  cdor_enables_type en_reg, next_en_reg;
  cdor_enables_type sel_en;
  logic sw_closed, next_sw_closed;
  logic limit_on, next_limit_on;
  logic mux1, next_mux1;
  logic mux2, next_mux2;
  cdor_addr_type addr_lo;
  cdor_byte_type status_view;
  logic sw_ovr, sw_on, lim_ovr, lim_en;

  // Upper address bits are don't-care, so registers alias every 16
  assign addr_lo = reg_addr_i[`CDOR_ADDR_BITS-1:0];

  // ==========================================================
  // Writable registers
  // Status and comparator addresses fall through untouched
  always_comb begin
    next_ctrl_reg = ctrl_reg;
    next_config_reg = config_reg;
    if (reg_wr_i) begin
      case (addr_lo)
        `CDOR_ADDR_CTRL: next_ctrl_reg = reg_wdata_i;
        `CDOR_ADDR_CONFIG: next_config_reg = reg_wdata_i & `CDOR_CONFIG_WR_MASK;
        default: next_ctrl_reg = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_reg <= `CDOR_CTRL_RST;
      config_reg <= `CDOR_CONFIG_RST;
    end else begin
      ctrl_reg <= next_ctrl_reg;
      config_reg <= next_config_reg;
    end
  end

  // ==========================================================
  // Comparator snapshot, one flop per input
  // Inputs are synchronous, so a single stage only aligns timing
  always_comb begin
    next_cmps_reg = {high_current_charger_seen_i,
                     neg_line_high_i,
                     pos_line_high_i,
                     line_voltage_tripped_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cmps_reg <= `CDOR_CMPS_RST;
    end else begin
      cmps_reg <= next_cmps_reg;
    end
  end

  // ==========================================================
  // Host traffic seen since reset
  // Any read or write counts; gates the default path on dead battery
  always_comb begin
    next_host_seen = host_seen | reg_wr_i | reg_rd_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      host_seen <= 1'b0;
    end else begin
      host_seen <= next_host_seen;
    end
  end

  // ==========================================================
  // Enable ownership select
  cdor_enable_mux u_enable_mux (
    .override_i(ctrl_reg[`CDOR_CTRL_OVERRIDE]),
    .reg_en_i(ctrl_reg[`CDOR_NUM_ENABLES-1:0]),
    .fsm_en_i(fsm_en_i),
    .en_o(sel_en)
  );

  // Registered so the analog side never sees a decode glitch
  always_comb begin
    next_en_reg = sel_en;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      en_reg <= '0;
    end else begin
      en_reg <= next_en_reg;
    end
  end

  assign single_ended_rx_on_o = en_reg[`CDOR_CTRL_SE_RX];
  assign contact_source_on_o = en_reg[`CDOR_CTRL_CONTACT];
  assign line_voltage_source_on_o = en_reg[`CDOR_CTRL_VSRC];
  assign detect_line_swap_o = en_reg[`CDOR_CTRL_SWAP];
  assign line_current_sink_on_o = en_reg[`CDOR_CTRL_ISINK];
  assign pos_line_pulldown_on_o = en_reg[`CDOR_CTRL_POS_PD];
  assign neg_line_pulldown_on_o = en_reg[`CDOR_CTRL_NEG_PD];

  // ==========================================================
  // Supply path: protection switch, current limit, muxes
  assign sw_on = config_reg[`CDOR_CFG_SWITCH_ON];
  assign sw_ovr = config_reg[`CDOR_CFG_SWITCH_OVR];
  assign lim_en = config_reg[`CDOR_CFG_LIMIT_EN];
  assign lim_ovr = config_reg[`CDOR_CFG_LIMIT_OVR];

  // Supply fault always wins; the host cannot close into overvoltage
  always_comb begin
    next_sw_closed = 1'b0;
    if (supply_ok_i) begin
      if (sw_ovr) begin
        next_sw_closed = sw_on;
      end else begin
        next_sw_closed = auto_switch_ok_i & (host_seen | ~DEAD_BATTERY);
      end
    end
    if (lim_ovr) begin
      next_limit_on = lim_en;
    end else begin
      next_limit_on = DEAD_BATTERY & ~(sw_ovr & sw_on);
    end
    next_mux1 = config_reg[`CDOR_CFG_MUX1];
    next_mux2 = config_reg[`CDOR_CFG_MUX2];
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sw_closed <= 1'b0;
      limit_on <= 1'b0;
      mux1 <= 1'b0;
      mux2 <= 1'b0;
    end else begin
      sw_closed <= next_sw_closed;
      limit_on <= next_limit_on;
      mux1 <= next_mux1;
      mux2 <= next_mux2;
    end
  end

  assign protection_switch_closed_o = sw_closed;
  assign current_limit_on_o = limit_on;
  assign mux1_on_o = mux1;
  assign mux2_on_o = mux2;

  // ==========================================================
  // Main status view
  always_comb begin
    status_view = `CDOR_STATUS_RST;
    status_view[`CDOR_STS_SUPPLY_OK] = supply_ok_i;
    status_view[`CDOR_STS_SWITCH_OPEN] = ~sw_closed;
    status_view[`CDOR_STS_LIMIT] = limit_on;
    status_view[`CDOR_STS_DONE] = det_done_i;
    status_view[7:`CDOR_STS_KIND_LSB] = charger_kind_i;
  end

  // ==========================================================
  // Read path, answered one cycle after the request
  // Reads of the control register return the stored bits, not the enables
  always_comb begin
    next_rvalid = reg_rd_i;
    next_rdata = rdata;
    if (reg_rd_i) begin
      case (addr_lo)
        `CDOR_ADDR_STATUS: next_rdata = status_view;
        `CDOR_ADDR_CONFIG: next_rdata = config_reg;
        `CDOR_ADDR_CTRL: next_rdata = ctrl_reg;
        `CDOR_ADDR_CMPS: next_rdata = {4'h0, cmps_reg};
        default: next_rdata = `CDOR_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_read(logic [3:0] a);
    reg_rd_i && (reg_addr_i[3:0] == a);
  endsequence

  sequence s_write(logic [3:0] a);
    reg_wr_i && (reg_addr_i[3:0] == a);
  endsequence

  // Host hands over to the detection machine after reset
  a_override_reset_clear: assert property (
    $fell(reset_i) |-> !ctrl_reg[`CDOR_CTRL_OVERRIDE] && !rvalid)
    else $error("override set after reset");

  // Machine-owned enables pass through one flop, a cycle later
  a_auto_enables_follow: assert property (
    !ctrl_reg[`CDOR_CTRL_OVERRIDE] |=> en_reg == $past(fsm_en_i))
    else $error("enables not from detection machine");

  // Host-owned enables mirror the stored bits
  a_manual_enables_follow: assert property (
    ctrl_reg[`CDOR_CTRL_OVERRIDE] |=>
      {neg_line_pulldown_on_o, pos_line_pulldown_on_o, line_current_sink_on_o,
       detect_line_swap_o, line_voltage_source_on_o, contact_source_on_o,
       single_ended_rx_on_o} == $past(ctrl_reg[6:0]))
    else $error("enables not from stored bits");

  // Write to control with override set reaches the swap pin within two edges
  a_ctrl_write_lands: assert property (
    s_write(`CDOR_ADDR_CTRL) ##0 reg_wdata_i[7] |=> ctrl_reg == $past(reg_wdata_i)
      ##1 detect_line_swap_o == $past(ctrl_reg[`CDOR_CTRL_SWAP]))
    else $error("control write lost");

  // Writes to read-only and undefined addresses leave control and config unchanged
  a_ro_write_ignored: assert property (
    reg_wr_i && (reg_addr_i[3:0] != `CDOR_ADDR_CTRL) &&
      (reg_addr_i[3:0] != `CDOR_ADDR_CONFIG)
      |=> $stable(ctrl_reg) && $stable(config_reg))
    else $error("write to read-only register took effect");

  // Upper address bits alias onto the same register
  a_addr_low_decode: assert property (
    s_read(`CDOR_ADDR_CTRL) |=> rvalid && rdata == $past(ctrl_reg))
    else $error("control read mismatch");

  // Comparator register shows the inputs of two cycles earlier
  a_cmp_read: assert property (
    s_read(`CDOR_ADDR_CMPS) |=> rdata == {4'h0, $past(high_current_charger_seen_i, 2),
      $past(neg_line_high_i, 2), $past(pos_line_high_i, 2),
      $past(line_voltage_tripped_i, 2)})
    else $error("comparator status mismatch");

  // Detection-complete flag lands in bit 4
  a_status_done: assert property (
    s_read(`CDOR_ADDR_STATUS) |=> rdata[`CDOR_STS_DONE] == $past(det_done_i))
    else $error("detection done flag mismatch");

  // Default limit is on with DEAD_BATTERY and off without it, until the host bypasses it
  a_limit_default: assert property (
    !lim_ovr && !(sw_ovr && sw_on) |=> current_limit_on_o == DEAD_BATTERY)
    else $error("default current limit wrong");

  // Switch enable plus override bypasses the limit and closes the path
  a_limit_bypass: assert property (
    !lim_ovr && sw_ovr && sw_on && supply_ok_i |=>
      !current_limit_on_o && protection_switch_closed_o)
    else $error("limit bypass failed");

  // No automatic path before any host traffic on dead battery
  a_path_waits_host: assert property (
    !host_seen && !sw_ovr |=> !protection_switch_closed_o || !DEAD_BATTERY)
    else $error("path closed without host traffic");

  // Answer pulse is one cycle wide per request
  a_read_pulse: assert property (
    reg_rd_i ##1 !reg_rd_i |=> !rvalid)
    else $error("read answer stretched");

endmodule

/* File: cdor_consts.svh */
`ifndef CDOR_CONSTS_SVH
`define CDOR_CONSTS_SVH

// ==========================================================
// Register map, low nibble of the register address only
`define CDOR_ADDR_BITS 4
`define CDOR_ADDR_STATUS 4'h0
`define CDOR_ADDR_CONFIG 4'h1
`define CDOR_ADDR_CTRL 4'h2
`define CDOR_ADDR_CMPS 4'h3

// ==========================================================
// Reset values and read answers
`define CDOR_STATUS_RST 8'h00
`define CDOR_CONFIG_RST 8'h20
`define CDOR_CTRL_RST 8'h00
`define CDOR_CMPS_RST 4'h0
`define CDOR_UNMAPPED_DATA 8'hff
`define CDOR_CONFIG_WR_MASK 8'h7f

// ==========================================================
// Charger control register fields
`define CDOR_NUM_ENABLES 7
`define CDOR_CTRL_OVERRIDE 7
`define CDOR_CTRL_SE_RX 0
`define CDOR_CTRL_CONTACT 1
`define CDOR_CTRL_VSRC 2
`define CDOR_CTRL_SWAP 3
`define CDOR_CTRL_ISINK 4
`define CDOR_CTRL_POS_PD 5
`define CDOR_CTRL_NEG_PD 6

// ==========================================================
// Configuration register fields
`define CDOR_CFG_SWITCH_ON 0
`define CDOR_CFG_LIMIT_EN 1
`define CDOR_CFG_SWITCH_OVR 2
`define CDOR_CFG_LIMIT_OVR 3
`define CDOR_CFG_MUX1 5
`define CDOR_CFG_MUX2 6

// ==========================================================
// Main status register fields
`define CDOR_STS_SUPPLY_OK 0
`define CDOR_STS_SWITCH_OPEN 2
`define CDOR_STS_LIMIT 3
`define CDOR_STS_DONE 4
`define CDOR_STS_KIND_LSB 5

`endif

/* File: cdor_pkg.sv */
package cdor_pkg;
  typedef logic [7:0] cdor_byte_type;
  typedef logic [6:0] cdor_enables_type;
  typedef logic [3:0] cdor_addr_type;
  typedef logic [2:0] cdor_kind_type;
endpackage

/* File: cdor_enable_mux.sv */
`timescale 1ns/1ps
`include "cdor_consts.svh"

module cdor_enable_mux
  import cdor_pkg::*;
(
  // Selection
  input wire logic override_i,
  // Enable sources
  input wire cdor_enables_type reg_en_i,
  input wire cdor_enables_type fsm_en_i,
  // Selected enables
  output cdor_enables_type en_o
);

  // ==========================================================
  // Per-enable owner select
  // Stored bits never reach the analog side unless the host owns it
  for (genvar i = 0; i < `CDOR_NUM_ENABLES; i++) begin : g_sel
    assign en_o[i] = override_i ? reg_en_i[i] : fsm_en_i[i];
  end

endmodule

/* File: cdor_host_model.sv */
`timescale 1ns/1ps

module cdor_host_model
  import cdor_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Register port towards the device
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output cdor_byte_type reg_wdata_o,
  input wire cdor_byte_type reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========================================================
  // Idle bus
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // Single byte write; a cycle gap first so strobes never toggle twice at once
  task automatic wr(input logic [7:0] a, input cdor_byte_type v);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a; // Released lines must not keep their value
    reg_wdata_o = ~v;
  endtask

  // Single byte read; answer expected one edge after the strobe
  task automatic rd(input logic [7:0] a, output cdor_byte_type v);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    v = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
endmodule

/* File: charger_detect_override_regs_test.sv */
`timescale 1ns/1ps

module charger_detect_override_regs_test
  import cdor_pkg::*;
;
  typedef struct packed {
    cdor_byte_type ctrl;
    cdor_enables_type fsm;
    logic [3:0] cmp;
    cdor_enables_type en;
  } cdor_row_type;

  // ==========================================================
  // Stimulus and observed signals
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  cdor_byte_type reg_wdata;
  cdor_byte_type reg_rdata;
  logic reg_rvalid;
  cdor_enables_type fsm_en_i;
  logic det_done_i;
  cdor_kind_type charger_kind_i;
  logic [3:0] cmp;
  logic supply_ok_i;
  logic auto_switch_ok_i;
  wire logic [6:0] en;
  logic sw_closed;
  logic limit_on;
  logic mux1_on;
  logic mux2_on;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  cdor_byte_type d;

  // Ordinary cases: control write, machine enables, comparators, enables
  cdor_row_type rows [10] = '{
    '{8'h00, 7'h55, 4'h1, 7'h55},
    '{8'h7f, 7'h2a, 4'h2, 7'h2a},
    '{8'h81, 7'h00, 4'h4, 7'h01},
    '{8'h82, 7'h7f, 4'h8, 7'h02},
    '{8'h84, 7'h00, 4'h0, 7'h04},
    '{8'h88, 7'h00, 4'h0, 7'h08},
    '{8'h90, 7'h00, 4'h0, 7'h10},
    '{8'ha0, 7'h00, 4'h0, 7'h20},
    '{8'hc0, 7'h00, 4'h0, 7'h40},
    '{8'hff, 7'h00, 4'hf, 7'h7f}
  };

  // ==========================================================
  // Device and host
  cdor_regs u_cdor_regs (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .fsm_en_i(fsm_en_i), .det_done_i(det_done_i), .charger_kind_i(charger_kind_i),
    .line_voltage_tripped_i(cmp[0]), .pos_line_high_i(cmp[1]),
    .neg_line_high_i(cmp[2]), .high_current_charger_seen_i(cmp[3]),
    .supply_ok_i(supply_ok_i), .auto_switch_ok_i(auto_switch_ok_i),
    .single_ended_rx_on_o(en[0]), .contact_source_on_o(en[1]),
    .line_voltage_source_on_o(en[2]), .detect_line_swap_o(en[3]),
    .line_current_sink_on_o(en[4]), .pos_line_pulldown_on_o(en[5]),
    .neg_line_pulldown_on_o(en[6]), .protection_switch_closed_o(sw_closed),
    .current_limit_on_o(limit_on), .mux1_on_o(mux1_on), .mux2_on_o(mux2_on)
  );

  cdor_host_model u_cdor_host_model (
    .sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid)
  );

  // ==========================================================
  // Clock, hang guard, helpers
  always #5 sys_clk_i = ~sys_clk_i;

  // Whole run needs about 130 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fsm_en_i = 7'h11;
    det_done_i = 1'b0;
    charger_kind_i = 3'h0;
    cmp = 4'h0;
    supply_ok_i = 1'b1;
    auto_switch_ok_i = 1'b1;
    tick(10);
    reset_i = 1'b0;
    tick(2);
    chk({1'b0, en}, 8'h11);
    chk({5'h00, limit_on, sw_closed, mux1_on}, 8'h05);
    u_cdor_host_model.rd(8'h00, d);
    chk(d, 8'h0d);
    u_cdor_host_model.rd(8'h02, d);
    chk(d, 8'h00);
    u_cdor_host_model.rd(8'h03, d);
    chk(d, 8'h00);
    chk({7'h00, sw_closed}, 8'h01);
    // Override only once detection reports done
    det_done_i = 1'b1;
    charger_kind_i = 3'h2;
    tick(1);
    u_cdor_host_model.rd(8'h00, d);
    chk(d, 8'h59);
    for (int i = 0; i < 10; i++) begin
      u_cdor_host_model.wr(8'h02, rows[i].ctrl);
      fsm_en_i = rows[i].fsm;
      cmp = rows[i].cmp;
      tick(1);
      chk({1'b0, en}, {1'b0, rows[i].en});
      u_cdor_host_model.rd(8'h02, d);
      chk(d, rows[i].ctrl);
      u_cdor_host_model.rd(8'h03, d);
      chk(d, {4'h0, rows[i].cmp});
    end
    // Writes to read-only places, then an unmapped read
    u_cdor_host_model.wr(8'h03, 8'h00);
    u_cdor_host_model.wr(8'h00, 8'h00);
    u_cdor_host_model.rd(8'h03, d);
    chk(d, 8'h0f);
    u_cdor_host_model.rd(8'h00, d);
    chk(d, 8'h59);
    u_cdor_host_model.rd(8'h05, d);
    chk(d, 8'hff);
    // Undefined and read-only writes leave both writable registers alone
    u_cdor_host_model.wr(8'h07, 8'h00);
    u_cdor_host_model.rd(8'h02, d);
    chk(d, 8'hff);
    u_cdor_host_model.rd(8'h01, d);
    chk(d, 8'h20);
    // Upper address bits are aliases
    u_cdor_host_model.wr(8'h12, 8'h00);
    fsm_en_i = 7'h33;
    tick(1);
    chk({1'b0, en}, 8'h33);
    u_cdor_host_model.rd(8'hf2, d);
    chk(d, 8'h00);
    // Limit bypass through switch enable and switch override
    u_cdor_host_model.wr(8'h01, 8'h05);
    tick(1);
    chk({6'h00, limit_on, sw_closed}, 8'h01);
    u_cdor_host_model.rd(8'h01, d);
    chk(d, 8'h05);
    // Config bit 7 is never stored; mux bits pass straight through
    u_cdor_host_model.wr(8'h01, 8'hc5);
    tick(1);
    chk({4'h0, mux2_on, mux1_on, limit_on, sw_closed}, 8'h09);
    u_cdor_host_model.rd(8'h01, d);
    chk(d, 8'h45);
    // Second reset in mid-run
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    tick(2);
    chk({4'h0, mux2_on, mux1_on, limit_on, sw_closed}, 8'h06);
    chk({1'b0, en}, 8'h33);
    u_cdor_host_model.rd(8'h02, d);
    chk(d, 8'h00);
    u_cdor_host_model.rd(8'h01, d);
    chk(d, 8'h20);
    summarize();
  end
endmodule
